//--- include/psc_pkg.sv
// Shared constants and types for the point and strobe command input block
package psc_pkg;

  localparam int          PSC_CLK_MHZ    = 250;
  localparam int          PSC_DEB_TIME_US = 1;
  localparam int          PSC_DEB_CYC    = PSC_DEB_TIME_US * PSC_CLK_MHZ;
  localparam int          PSC_CNT_W      = 8;
  localparam int          PSC_NIN        = 13;
  localparam int          PSC_PT_W       = 6;
  localparam logic [2:0]  PSC_PT_BASE    = 3'h3;
  localparam logic [2:0]  PSC_PT_MAXBITS = 3'h6;

  // Bit positions inside the contact vector
  localparam int          PSC_I_STB      = 6;
  localparam int          PSC_I_CCW      = 7;
  localparam int          PSC_I_CW       = 8;
  localparam int          PSC_I_HOME     = 9;
  localparam int          PSC_I_SRV      = 10;
  localparam int          PSC_I_MFA      = 11;
  localparam int          PSC_I_MFB      = 12;

  // Multi-function selections
  localparam logic [2:0]  PSC_MF_NONE    = 3'h0;
  localparam logic [2:0]  PSC_MF_ISTOP   = 3'h1;
  localparam logic [2:0]  PSC_MF_TSTOP   = 3'h2;
  localparam logic [2:0]  PSC_MF_DSTOP   = 3'h3;
  localparam logic [2:0]  PSC_MF_JOGP    = 3'h4;
  localparam logic [2:0]  PSC_MF_JOGN    = 3'h5;
  localparam logic [2:0]  PSC_MF_ACLR    = 3'h6;

  typedef enum logic [2:0] {
    PSC_ST_IDLE = 3'b001,
    PSC_ST_EXEC = 3'b010,
    PSC_ST_HOLD = 3'b100
  } psc_state_e;

  typedef enum logic [2:0] {
    PSC_CMD_MOVE  = 3'h0,
    PSC_CMD_ACLR  = 3'h1,
    PSC_CMD_HOME  = 3'h2,
    PSC_CMD_JOGP  = 3'h3,
    PSC_CMD_JOGN  = 3'h4
  } psc_cmd_e;

  // Contact levels: 1 means closed to the control supply common
  typedef struct packed {
    logic                multi_func_in_b;
    logic                multi_func_in_a;
    logic                servo_enable_in;
    logic                home_sensor_in;
    logic                cw_travel_inhibit;
    logic                ccw_travel_inhibit;
    logic                command_strobe;
    logic [PSC_PT_W-1:0] point_sel;
  } psc_contacts_s;

  typedef struct packed {
    logic [2:0] point_count_setting;
    logic       point_polarity_setting;
    logic       travel_inhibit_valid_setting;
    logic       travel_inhibit_polarity_setting;
    logic [1:0] travel_inhibit_action_setting;
    logic       home_sensor_polarity_setting;
    logic [1:0] servo_off_sequence_setting;
    logic       servo_enable_valid_setting;
    logic [2:0] multi_func_a_select;
    logic [2:0] multi_func_b_select;
    logic       multi_func_a_polarity;
    logic       multi_func_b_polarity;
  } psc_cfg_s;

  typedef struct packed {
    logic istop;
    logic tstop;
    logic dstop;
    logic jog_pos;
    logic jog_neg;
  } psc_mf_s;

endpackage

//--- verilog/psc_point_strobe_cmd.sv
// Point select and strobe command interpreter with discrete control inputs
`timescale 1ns/1ps

module psc_point_strobe_cmd #(
  parameter int DEB_CYC = psc_pkg::PSC_DEB_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire psc_pkg::psc_contacts_s        contacts,
  input  wire psc_pkg::psc_cfg_s             cfg,
  input  wire logic                          cmd_done,
  output logic                               cmd_valid,
  output psc_pkg::psc_cmd_e                  cmd_kind,
  output logic [psc_pkg::PSC_PT_W-1:0]       cmd_point,
  output logic                               busy,
  output logic                               alarm_clear,
  output logic                               servo_on,
  output logic                               dyn_brake,
  output logic                               dev_clear,
  output logic                               home_active,
  output logic                               ccw_blocked,
  output logic                               cw_blocked,
  output logic [1:0]                         inhibit_action,
  output psc_pkg::psc_mf_s                   mf_req
);
  import psc_pkg::*;

  typedef struct packed {
    logic [PSC_NIN-1:0]                sync1;
    logic [PSC_NIN-1:0]                sync2;
    logic [PSC_NIN-1:0][PSC_CNT_W-1:0] cnt;
    logic [PSC_NIN-1:0]                filt;
    psc_state_e                        fsm;
    logic                              cmd_valid;
    psc_cmd_e                          cmd_kind;
    logic [PSC_PT_W-1:0]               cmd_point;
    logic                              busy;
    logic                              alarm_clear;
    logic                              servo_on;
    logic                              dyn_brake;
    logic                              dev_clear;
    logic                              home_active;
    logic                              ccw_blocked;
    logic                              cw_blocked;
    logic [1:0]                        inhibit_action;
    psc_mf_s                           mf_req;
    logic                              mf_aclr_prev;
  } psc_regs_s;

  localparam logic [PSC_CNT_W-1:0] DEB_LAST = PSC_CNT_W'(DEB_CYC - 1);

  psc_regs_s r_ff;
  psc_regs_s nxt_r;

  logic [2:0]          pt_bits;
  logic [PSC_PT_W-1:0] pt_max;
  logic [PSC_PT_W-1:0] pt_sel;
  logic                stb_act;
  logic                srv_act;
  logic                ccw_act;
  logic                cw_act;
  logic                mfa_act;
  logic                mfb_act;
  logic                mf_aclr;
  logic                servo_now;

  always_comb begin
    // Settings beyond six lines clamp to six
    // Compared at four bits so that large settings cannot wrap past the clamp
    pt_bits = (4'(cfg.point_count_setting) + 4'(PSC_PT_BASE) > 4'(PSC_PT_MAXBITS)) ? PSC_PT_MAXBITS
              : 3'(cfg.point_count_setting + PSC_PT_BASE);
    pt_max  = PSC_PT_W'((7'h01 << pt_bits) - 7'h01);
    // Unused upper lines are masked so they cannot alias a special point
    pt_sel  = (cfg.point_polarity_setting ? r_ff.filt[PSC_PT_W-1:0]
               : ~r_ff.filt[PSC_PT_W-1:0]) & pt_max;
    stb_act = r_ff.filt[PSC_I_STB];
    srv_act = cfg.servo_enable_valid_setting ? r_ff.filt[PSC_I_SRV] : 1'b1;
    ccw_act = cfg.travel_inhibit_valid_setting
              & (r_ff.filt[PSC_I_CCW] == cfg.travel_inhibit_polarity_setting);
    cw_act  = cfg.travel_inhibit_valid_setting
              & (r_ff.filt[PSC_I_CW] == cfg.travel_inhibit_polarity_setting);
    mfa_act = r_ff.filt[PSC_I_MFA] ^ ~cfg.multi_func_a_polarity;
    mfb_act = r_ff.filt[PSC_I_MFB] ^ ~cfg.multi_func_b_polarity;
    mf_aclr = (mfa_act & (cfg.multi_func_a_select == PSC_MF_ACLR))
              | (mfb_act & (cfg.multi_func_b_select == PSC_MF_ACLR));
    servo_now = srv_act;
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sync1 = contacts;
    nxt_r.sync2 = r_ff.sync1;
    // A level is accepted only after it stays put for the whole window
    for (int i = 0; i < PSC_NIN; i++) begin
      if (r_ff.sync2[i] == r_ff.filt[i]) begin
        nxt_r.cnt[i] = '0;
      end else if (r_ff.cnt[i] == DEB_LAST) begin
        nxt_r.cnt[i]  = '0;
        nxt_r.filt[i] = r_ff.sync2[i];
      end else begin
        nxt_r.cnt[i] = r_ff.cnt[i] + PSC_CNT_W'(1);
      end
    end

    nxt_r.servo_on       = servo_now;
    nxt_r.dyn_brake      = ~servo_now & cfg.servo_off_sequence_setting[0];
    nxt_r.dev_clear      = ~servo_now & cfg.servo_off_sequence_setting[1];
    nxt_r.home_active    = r_ff.filt[PSC_I_HOME] ^ cfg.home_sensor_polarity_setting;
    nxt_r.ccw_blocked    = ccw_act;
    nxt_r.cw_blocked     = cw_act;
    nxt_r.inhibit_action = cfg.travel_inhibit_action_setting;

    nxt_r.mf_req.istop   = (mfa_act & (cfg.multi_func_a_select == PSC_MF_ISTOP))
                           | (mfb_act & (cfg.multi_func_b_select == PSC_MF_ISTOP));
    nxt_r.mf_req.tstop   = (mfa_act & (cfg.multi_func_a_select == PSC_MF_TSTOP))
                           | (mfb_act & (cfg.multi_func_b_select == PSC_MF_TSTOP));
    nxt_r.mf_req.dstop   = (mfa_act & (cfg.multi_func_a_select == PSC_MF_DSTOP))
                           | (mfb_act & (cfg.multi_func_b_select == PSC_MF_DSTOP));
    // Jogs requested from the contacts still obey the travel inhibits
    nxt_r.mf_req.jog_pos = ~cw_act & ((mfa_act & (cfg.multi_func_a_select == PSC_MF_JOGP))
                           | (mfb_act & (cfg.multi_func_b_select == PSC_MF_JOGP)));
    nxt_r.mf_req.jog_neg = ~ccw_act & ((mfa_act & (cfg.multi_func_a_select == PSC_MF_JOGN))
                           | (mfb_act & (cfg.multi_func_b_select == PSC_MF_JOGN)));
    nxt_r.mf_aclr_prev   = mf_aclr;

    nxt_r.cmd_valid   = 1'b0;
    nxt_r.alarm_clear = mf_aclr & ~r_ff.mf_aclr_prev;

    case (r_ff.fsm)
      PSC_ST_IDLE: begin
        if (stb_act) begin
          nxt_r.busy      = 1'b1;
          nxt_r.cmd_point = pt_sel;
          if (pt_sel == '0) begin
            nxt_r.alarm_clear = 1'b1;
            nxt_r.fsm         = PSC_ST_HOLD;
          end else if (pt_sel == pt_max) begin
            nxt_r.cmd_valid = 1'b1;
            nxt_r.cmd_kind  = PSC_CMD_HOME;
            nxt_r.fsm       = PSC_ST_EXEC;
          end else if (pt_sel == pt_max - PSC_PT_W'(1)) begin
            // Normal rotation is taken as the CW direction
            nxt_r.cmd_valid = ~cw_act;
            nxt_r.cmd_kind  = PSC_CMD_JOGP;
            nxt_r.fsm       = cw_act ? PSC_ST_HOLD : PSC_ST_EXEC;
          end else if (pt_sel == pt_max - PSC_PT_W'(2)) begin
            nxt_r.cmd_valid = ~ccw_act;
            nxt_r.cmd_kind  = PSC_CMD_JOGN;
            nxt_r.fsm       = ccw_act ? PSC_ST_HOLD : PSC_ST_EXEC;
          end else begin
            nxt_r.cmd_valid = 1'b1;
            nxt_r.cmd_kind  = PSC_CMD_MOVE;
            nxt_r.fsm       = PSC_ST_EXEC;
          end
        end
      end
      PSC_ST_EXEC: begin
        // Strobe edges here are ignored
        if (cmd_done) begin
          nxt_r.fsm = PSC_ST_HOLD;
        end
      end
      PSC_ST_HOLD: begin
        if (!stb_act) begin
          nxt_r.busy = 1'b0;
          nxt_r.fsm  = PSC_ST_IDLE;
        end
      end
      default: begin
        nxt_r.fsm  = PSC_ST_IDLE;
        nxt_r.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r_ff          <= '0;
      r_ff.fsm      <= PSC_ST_IDLE;
      r_ff.cmd_kind <= PSC_CMD_MOVE;
      // Seen as active out of reset so an open-active input cannot fake an edge
      r_ff.mf_aclr_prev <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cmd_valid      = r_ff.cmd_valid;
  assign cmd_kind       = r_ff.cmd_kind;
  assign cmd_point      = r_ff.cmd_point;
  assign busy           = r_ff.busy;
  assign alarm_clear    = r_ff.alarm_clear;
  assign servo_on       = r_ff.servo_on;
  assign dyn_brake      = r_ff.dyn_brake;
  assign dev_clear      = r_ff.dev_clear;
  assign home_active    = r_ff.home_active;
  assign ccw_blocked    = r_ff.ccw_blocked;
  assign cw_blocked     = r_ff.cw_blocked;
  assign inhibit_action = r_ff.inhibit_action;
  assign mf_req         = r_ff.mf_req;

  AST_PT0_CLEARS: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && pt_sel == '0) |=> (alarm_clear && !cmd_valid))
    else $error("point 0 strobe did not clear alarm");
  AST_MAX_HOMES: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && pt_sel == pt_max && pt_sel != '0)
    |=> (cmd_valid && cmd_kind == PSC_CMD_HOME))
    else $error("max point did not home");
  AST_JOGP: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && pt_sel == pt_max - PSC_PT_W'(1) && pt_sel != '0)
    |=> (cmd_kind == PSC_CMD_JOGP))
    else $error("max-1 did not select normal jog");
  AST_JOGN: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && pt_sel == pt_max - PSC_PT_W'(2) && pt_sel != '0)
    |=> (cmd_kind == PSC_CMD_JOGN))
    else $error("max-2 did not select reverse jog");
  AST_NO_CCW: assert property (@(posedge mclk) disable iff (srst)
    (cmd_valid && cmd_kind == PSC_CMD_JOGN) |-> !$past(ccw_act))
    else $error("reverse jog issued under CCW inhibit");
  AST_NO_CW: assert property (@(posedge mclk) disable iff (srst)
    (cmd_valid && cmd_kind == PSC_CMD_JOGP) |-> !$past(cw_act))
    else $error("normal jog issued under CW inhibit");
  AST_SRV_OFF: assert property (@(posedge mclk) disable iff (srst)
    (!srv_act && cfg.servo_off_sequence_setting == 2'h3) ##1 $stable(cfg.servo_off_sequence_setting)
    |-> (!servo_on && dyn_brake && dev_clear))
    else $error("servo-off sequence not applied");
  AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (busy && stb_act) |=> busy)
    else $error("busy dropped while strobe closed");
  AST_ONE_CMD: assert property (@(posedge mclk) disable iff (srst)
    cmd_valid |=> (!cmd_valid)[*2])
    else $error("second command taken while busy");
  AST_DEB: assert property (@(posedge mclk) disable iff (srst)
    $changed(r_ff.filt[PSC_I_STB]) |-> $past(r_ff.cnt[PSC_I_STB]) == DEB_LAST)
    else $error("strobe filter changed before window");
  AST_MOVE_ISSUE: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && pt_sel != '0 && pt_sel < pt_max - PSC_PT_W'(2))
    |=> (cmd_valid && cmd_kind == PSC_CMD_MOVE && busy))
    else $error("ordinary point did not issue a move");
  AST_PT_LATCH: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act) |=> (cmd_point == $past(pt_sel)))
    else $error("selected point not captured");
  AST_PT_POL: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act && !cfg.point_polarity_setting)
    |=> (cmd_point == ($past(~r_ff.filt[PSC_PT_W-1:0]) & $past(pt_max))))
    else $error("open-active point lines not inverted");
  AST_BUSY_SET: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_IDLE && stb_act) |=> busy)
    else $error("busy not raised on accepted strobe");
  AST_BUSY_DROP: assert property (@(posedge mclk) disable iff (srst)
    (r_ff.fsm == PSC_ST_HOLD && busy && !stb_act) |=> !busy)
    else $error("busy kept after strobe opened");
  AST_SERVO_ENABLE_IN: assert property (@(posedge mclk) disable iff (srst)
    (cfg.servo_enable_valid_setting && r_ff.filt[PSC_I_SRV]) |=> servo_on)
    else $error("closed servo enable did not give servo-on");
  AST_SRV_IGNORE: assert property (@(posedge mclk) disable iff (srst)
    !cfg.servo_enable_valid_setting |=> servo_on)
    else $error("invalid servo enable input not ignored");
  AST_HOME_POL: assert property (@(posedge mclk) disable iff (srst)
    (!cfg.home_sensor_polarity_setting && r_ff.filt[PSC_I_HOME]) |=> home_active)
    else $error("closed home sensor not active by default");
  AST_ACTION: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> (inhibit_action == $past(cfg.travel_inhibit_action_setting)))
    else $error("inhibit action not passed on");
  AST_INHIBIT_OFF: assert property (@(posedge mclk) disable iff (srst)
    !cfg.travel_inhibit_valid_setting |=> (!ccw_blocked && !cw_blocked))
    else $error("travel inhibit honoured while invalid");
  AST_MF_STOP: assert property (@(posedge mclk) disable iff (srst)
    (mfa_act && cfg.multi_func_a_select == PSC_MF_ISTOP) |=> mf_req.istop)
    else $error("instantaneous stop not requested");
  AST_MF_POL: assert property (@(posedge mclk) disable iff (srst)
    (!r_ff.filt[PSC_I_MFB] && !cfg.multi_func_b_polarity && cfg.multi_func_b_select == PSC_MF_ISTOP)
    |=> mf_req.istop)
    else $error("open-active multi-function input ignored");

  COV_MOVE: cover property (@(posedge mclk) disable iff (srst)
    cmd_valid && cmd_kind == PSC_CMD_MOVE);
  COV_HOME: cover property (@(posedge mclk) disable iff (srst)
    cmd_valid && cmd_kind == PSC_CMD_HOME);
  COV_BLOCKED: cover property (@(posedge mclk) disable iff (srst)
    r_ff.fsm == PSC_ST_IDLE && stb_act && cw_act && pt_sel == pt_max - PSC_PT_W'(1));
  COV_RELEASE: cover property (@(posedge mclk) disable iff (srst)
    busy ##1 !busy);
  COV_JOGN: cover property (@(posedge mclk) disable iff (srst)
    cmd_valid && cmd_kind == PSC_CMD_JOGN);

endmodule

//--- bench/psc_host_model.sv
// Host controller model driving the point select lines and the strobe contact
`timescale 1ns/1ps
module psc_host_model #(
  parameter int SETTLE = 10
) (
  input  wire logic       mclk,
  input  wire logic       busy,
  output logic [5:0]      point_sel,
  output logic            command_strobe
);
  initial begin
    point_sel = 6'h00;
    command_strobe = 1'b0;
  end

  // Closes the strobe on settled lines and holds it until busy plus a minimum time
  task automatic press(input logic [5:0] lines);
    int n;
    @(negedge mclk);
    point_sel = lines;
    repeat (SETTLE) @(negedge mclk);
    command_strobe = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    repeat (SETTLE) @(negedge mclk);
  endtask

  // A strobe never seen acknowledged stays closed, and do_cmd has already flagged it at its busy check
  task automatic release_strobe();
    @(negedge mclk);
    if (busy === 1'b1) command_strobe = 1'b0;
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking testbench for the point and strobe command input block
`timescale 1ns/1ps
module tb_top;
  import psc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, cmd_done = 1'b0;
  logic ccw = 1'b1, cw = 1'b1, home = 1'b0, srv = 1'b1, mfa = 1'b0, mfb = 1'b0;
  logic [5:0] pt_lines;
  logic       strobe;
  psc_contacts_s contacts;
  psc_cfg_s   cfg = '{3'h3, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 3'h0, 3'h0, 1'b1, 1'b1};
  logic cmd_valid, busy, alarm_clear, servo_on, dyn_brake, dev_clear, home_active, ccw_blocked, cw_blocked;
  psc_cmd_e   cmd_kind, k;
  logic [5:0] cmd_point, p;
  logic [1:0] inhibit_action;
  psc_mf_s    mf_req;
  int bad_count = 0, checked = 0, nval = 0, nacl = 0, dcnt = 0, cyc = 0;
  logic [2:0] t_cnt[8] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [5:0] t_pt[8]  = '{6'h05, 6'h3f, 6'h3e, 6'h3d, 6'h07, 6'h06, 6'h05, 6'h3d};
  logic [5:0] t_exp[8] = '{6'h05, 6'h3f, 6'h3e, 6'h3d, 6'h07, 6'h06, 6'h05, 6'h05};
  psc_cmd_e   t_kind[8] = '{PSC_CMD_MOVE, PSC_CMD_HOME, PSC_CMD_JOGP, PSC_CMD_JOGN,
                            PSC_CMD_HOME, PSC_CMD_JOGP, PSC_CMD_JOGN, PSC_CMD_JOGN};

  assign contacts = {mfb, mfa, srv, home, cw, ccw, strobe, pt_lines};
  always #2 mclk = ~mclk;

  psc_host_model host (.mclk(mclk), .busy(busy), .point_sel(pt_lines), .command_strobe(strobe));

  psc_point_strobe_cmd #(.DEB_CYC(4)) uut (
    .mclk(mclk), .srst(srst), .contacts(contacts), .cfg(cfg), .cmd_done(cmd_done),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_point(cmd_point), .busy(busy),
    .alarm_clear(alarm_clear), .servo_on(servo_on), .dyn_brake(dyn_brake), .dev_clear(dev_clear),
    .home_active(home_active), .ccw_blocked(ccw_blocked), .cw_blocked(cw_blocked),
    .inhibit_action(inhibit_action), .mf_req(mf_req));

  // Motion core stand-in: finishes each issued command a few cycles later
  always @(posedge mclk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      nval++;
      k = cmd_kind;
      p = cmd_point;
      dcnt = 3;
    end
    if (alarm_clear === 1'b1) nacl++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  always @(negedge mclk) begin
    cmd_done = (dcnt == 1);
    if (dcnt > 0) dcnt--;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Strobe stays closed long after the core finishes, so a retrigger would show
  task automatic do_cmd(input logic [5:0] lines);
    int n;
    nval = 0;
    nacl = 0;
    host.press(lines);
    tick(20);
    chk(8'(busy), 8'h01);
    host.release_strobe();
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      tick(1);
      n++;
    end
    chk(8'(busy), 8'h00);
  endtask

  initial begin
    tick(8);
    srst = 1'b0;
    tick(2);
    chk(8'(busy), 8'h00);
    chk(8'(cmd_kind), 8'(PSC_CMD_MOVE));
    chk(8'(servo_on), 8'h01);
    tick(30);
    for (int i = 0; i < 8; i++) begin
      cfg.point_count_setting = t_cnt[i];
      do_cmd(t_pt[i]);
      chk(8'(nval), 8'h01);
      chk(8'(k), 8'(t_kind[i]));
      chk(8'(p), 8'(t_exp[i]));
    end
    cfg.point_count_setting = 3'h5;
    do_cmd(6'h3f);
    chk(8'(k), 8'(PSC_CMD_HOME));
    chk(8'(p), 8'h3f);
    cfg.point_count_setting = 3'h3;
    do_cmd(6'h00);
    chk(8'(nacl), 8'h01);
    chk(8'(nval), 8'h00);
    cfg.point_polarity_setting = 1'b0;
    do_cmd(~6'h09);
    chk(8'(p), 8'h09);
    cfg.travel_inhibit_valid_setting = 1'b1;
    cfg.travel_inhibit_action_setting = 2'h2;
    cw = 1'b0;
    tick(12);
    chk(8'(cw_blocked), 8'h01);
    chk(8'(ccw_blocked), 8'h00);
    chk(8'(inhibit_action), 8'h02);
    do_cmd(~6'h3e);
    chk(8'(nval), 8'h00);
    cw = 1'b1;
    ccw = 1'b0;
    tick(12);
    chk(8'(ccw_blocked), 8'h01);
    do_cmd(~6'h3d);
    chk(8'(nval), 8'h00);
    cfg.travel_inhibit_polarity_setting = 1'b1;
    tick(4);
    chk(8'(cw_blocked), 8'h01);
    chk(8'(ccw_blocked), 8'h00);
    cfg.travel_inhibit_polarity_setting = 1'b0;
    cfg.travel_inhibit_valid_setting = 1'b0;
    do_cmd(~6'h3d);
    chk(8'(nval), 8'h01);
    home = 1'b1;
    tick(12);
    chk(8'(home_active), 8'h01);
    cfg.home_sensor_polarity_setting = 1'b1;
    tick(4);
    chk(8'(home_active), 8'h00);
    cfg.servo_enable_valid_setting = 1'b1;
    cfg.servo_off_sequence_setting = 2'h3;
    srv = 1'b0;
    tick(12);
    chk(8'(servo_on), 8'h00);
    chk(8'({dyn_brake, dev_clear}), 8'h03);
    cfg.servo_off_sequence_setting = 2'h0;
    tick(4);
    chk(8'({dyn_brake, dev_clear}), 8'h00);
    srv = 1'b1;
    tick(12);
    chk(8'(servo_on), 8'h01);
    mfa = 1'b1;
    for (int s = 1; s < 6; s++) begin
      cfg.multi_func_a_select = 3'(s);
      tick(12);
      chk(8'(mf_req), 8'h10 >> (s - 1));
    end
    cfg.multi_func_a_select = 3'h0;
    cfg.multi_func_b_select = 3'h1;
    cfg.multi_func_b_polarity = 1'b0;
    tick(12);
    chk(8'(mf_req), 8'h10);
    cfg.multi_func_b_select = 3'h6;
    cfg.multi_func_b_polarity = 1'b1;
    tick(12);
    nacl = 0;
    mfb = 1'b1;
    tick(2);
    mfb = 1'b0;
    tick(12);
    chk(8'(nacl), 8'h00);
    mfb = 1'b1;
    tick(12);
    chk(8'(nacl), 8'h01);
    summarize();
  end
endmodule
